// file: core/i2cdma_regs.vh
// Purpose: constants of the i2c slave sram dma engine
// Assumes: included by bare name from the design files
// Notes:   definitions only
`ifndef I2CDMA_REGS_VH
`define I2CDMA_REGS_VH

// ----------------------------------------------------------------
// transmit fifo shape
// ----------------------------------------------------------------
`define I2CDMA_TXF_DEPTH   4
`define I2CDMA_TXF_AW      2
`define I2CDMA_TXF_LW      3

// ----------------------------------------------------------------
// sram window
// ----------------------------------------------------------------
`define I2CDMA_PTR_W       8
`define I2CDMA_BASE_W      3
`define I2CDMA_MADDR_W     11

// ----------------------------------------------------------------
// reset values and fixed codes
// ----------------------------------------------------------------
`define I2CDMA_PTR_RST     8'h00
`define I2CDMA_ARM_RST     1'b1
`define I2CDMA_IDLE_BYTE   8'hFF
`define I2CDMA_BITS_BYTE   4'h8
`define I2CDMA_LAST_TXBIT  4'h7

`endif

// file: core/i2cdma_txfifo.v
// Purpose: transmit fifo between sram fetches and the i2c shifter
// Assumes: push never offered while full; show-ahead read data
// Notes:   flush empties it in one cycle
`include "i2cdma_regs.vh"

module i2cdma_txfifo (
  // clock and reset
  input  wire       clk,
  input  wire       rst,
  // control
  input  wire       flush,
  // fill side
  input  wire       push,
  input  wire [7:0] wdata,
  // drain side
  input  wire       pop,
  output wire [7:0] rdata,
  // status
  output wire       full,
  output wire       empty,
  output wire [`I2CDMA_TXF_LW-1:0] level
);

  reg [7:0]                 mem_reg [0:`I2CDMA_TXF_DEPTH-1];
  reg [`I2CDMA_TXF_AW-1:0]  wr_ptr_reg;
  reg [`I2CDMA_TXF_AW-1:0]  rd_ptr_reg;
  reg [`I2CDMA_TXF_LW-1:0]  cnt_reg;
  wire                      do_push;
  wire                      do_pop;

  assign full    = (cnt_reg == `I2CDMA_TXF_DEPTH);
  assign empty   = (cnt_reg == {`I2CDMA_TXF_LW{1'b0}});
  assign level   = cnt_reg;
  assign rdata   = mem_reg[rd_ptr_reg];
  assign do_push = push & ~full;
  assign do_pop  = pop & ~empty;

  always @(posedge clk) begin
    if (do_push) begin
      mem_reg[wr_ptr_reg] <= wdata;
    end
  end

  always @(posedge clk) begin
    if (rst || flush) begin
      wr_ptr_reg <= {`I2CDMA_TXF_AW{1'b0}};
      rd_ptr_reg <= {`I2CDMA_TXF_AW{1'b0}};
      cnt_reg    <= {`I2CDMA_TXF_LW{1'b0}};
    end else begin
      if (do_push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (do_push && !do_pop) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else if (do_pop && !do_push) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end

endmodule // i2cdma_txfifo

// file: core/i2cdma_top.v
// Purpose: i2c slave port with dma access to a 256-byte sram window
// Assumes: scl/sda arrive asynchronously; sram has one-cycle read latency
// Notes:   no clock stretching; empty fifo transmits 8'hFF
`include "i2cdma_regs.vh"

// What this block does
// - two read modes, read-ahead by default
// - read-ahead starts fetching during address ack
// - keep fetching until fifo full, then pause
// - refill fifo entry as soon as popped
// - leftover prefetched bytes stay in fifo
// - firmware may keep or flush leftovers
// - eeprom mode fetches one byte during address ack
// - eeprom mode fetches again per master ack
// - no further eeprom-mode fetch after master nack; read-ahead keeps refilling until stop or start
// - write byte to sram during its ack
// - writes unchecked, pointer wraps freely
// - window is 256 bytes on a 256-byte boundary set by win_base
// - first write byte after initial start loads pointer
// - initial start is after reset or stop
// - pointer increments after each sram access
module i2cdma_top (
  // clock and reset
  input  wire                        clk,
  input  wire                        rst,
  // i2c pins
  input  wire                        scl_in,
  input  wire                        sda_in,
  output wire                        sda_out,
  output wire                        sda_oe,
  // firmware configuration
  input  wire                        dma_en,
  input  wire                        eeprom_mode,
  input  wire [`I2CDMA_BASE_W-1:0]   win_base,
  input  wire [6:0]                  slave_addr,
  input  wire                        fifo_flush,
  // sram port
  output wire [`I2CDMA_MADDR_W-1:0]  mem_addr,
  output wire                        mem_rd_en,
  output wire                        mem_wr_en,
  output wire [7:0]                  mem_wdata,
  input  wire [7:0]                  mem_rdata,
  // status
  output wire [`I2CDMA_PTR_W-1:0]    ptr,
  output wire [`I2CDMA_TXF_LW-1:0]   fifo_level,
  output wire                        bus_busy
);

  // --------------------------------------------------------------
  // states
  // --------------------------------------------------------------
  localparam [6:0] S_IDLE = 7'h01;
  localparam [6:0] S_ADDR = 7'h02;
  localparam [6:0] S_AACK = 7'h04;
  localparam [6:0] S_RX   = 7'h08;
  localparam [6:0] S_DACK = 7'h10;
  localparam [6:0] S_TX   = 7'h20;
  localparam [6:0] S_MACK = 7'h40;

  reg  [6:0]                 state_reg;
  reg  [3:0]                 bit_cnt_reg;
  reg  [7:0]                 shift_reg;
  reg                        rw_reg;
  reg                        arm_reg;
  reg                        load_pend_reg;
  reg  [`I2CDMA_PTR_W-1:0]   ptr_reg;
  reg                        ra_active_reg;
  reg                        ee_pend_reg;
  reg                        busy_reg;
  reg                        rd_dly_reg;
  reg                        sda_oe_reg;
  reg                        sda_out_reg;
  reg                        mem_rd_reg;
  reg                        mem_wr_reg;
  reg  [7:0]                 mem_wdata_reg;
  reg  [`I2CDMA_MADDR_W-1:0] mem_addr_reg;
  reg                        bus_busy_reg;
  reg                        scl_m_reg;
  reg                        scl_s_reg;
  reg                        scl_q_reg;
  reg                        sda_m_reg;
  reg                        sda_s_reg;
  reg                        sda_q_reg;
  reg                        pop;
  wire                       fifo_full;
  wire                       fifo_empty;
  wire [7:0]                 fifo_rdata;
  wire                       scl_rise;
  wire                       scl_fall;
  wire                       start_seen;
  wire                       stop_seen;
  wire                       fetch_go;
  wire [7:0]                 tx_byte;

  // --------------------------------------------------------------
  // pin synchronisers and bus condition detection
  // --------------------------------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      scl_m_reg <= 1'b1;
      scl_s_reg <= 1'b1;
      scl_q_reg <= 1'b1;
      sda_m_reg <= 1'b1;
      sda_s_reg <= 1'b1;
      sda_q_reg <= 1'b1;
    end else begin
      scl_m_reg <= scl_in;
      scl_s_reg <= scl_m_reg;
      scl_q_reg <= scl_s_reg;
      sda_m_reg <= sda_in;
      sda_s_reg <= sda_m_reg;
      sda_q_reg <= sda_s_reg;
    end
  end

  assign scl_rise   = scl_s_reg & ~scl_q_reg;
  assign scl_fall   = ~scl_s_reg & scl_q_reg;
  assign start_seen = scl_s_reg & scl_q_reg & sda_q_reg & ~sda_s_reg;
  assign stop_seen  = scl_s_reg & scl_q_reg & ~sda_q_reg & sda_s_reg;

  // --------------------------------------------------------------
  // transmit fifo
  // --------------------------------------------------------------
  assign tx_byte  = fifo_empty ? `I2CDMA_IDLE_BYTE : fifo_rdata;
  // one fetch in flight at a time, so a free entry is guaranteed
  assign fetch_go = ~busy_reg & ~fifo_full & ~fifo_flush & (ra_active_reg | ee_pend_reg);

  always @* begin
    pop = 1'b0;
    if (!start_seen && !stop_seen && scl_fall && rw_reg &&
        (state_reg == S_AACK || state_reg == S_MACK)) begin
      pop = 1'b1;
    end
  end

  i2cdma_txfifo u_txfifo (
    .clk   (clk),
    .rst   (rst),
    .flush (fifo_flush),
    .push  (rd_dly_reg),
    .wdata (mem_rdata),
    .pop   (pop),
    .rdata (fifo_rdata),
    .full  (fifo_full),
    .empty (fifo_empty),
    .level (fifo_level)
  );

  // --------------------------------------------------------------
  // protocol engine and dma
  // --------------------------------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      state_reg     <= S_IDLE;
      bit_cnt_reg   <= 4'h0;
      shift_reg     <= 8'h00;
      rw_reg        <= 1'b0;
      arm_reg       <= `I2CDMA_ARM_RST;
      load_pend_reg <= 1'b0;
      ptr_reg       <= `I2CDMA_PTR_RST;
      ra_active_reg <= 1'b0;
      ee_pend_reg   <= 1'b0;
      busy_reg      <= 1'b0;
      rd_dly_reg    <= 1'b0;
      sda_oe_reg    <= 1'b0;
      sda_out_reg   <= 1'b0;
      mem_rd_reg    <= 1'b0;
      mem_wr_reg    <= 1'b0;
      mem_wdata_reg <= 8'h00;
      mem_addr_reg  <= {`I2CDMA_MADDR_W{1'b0}};
      bus_busy_reg  <= 1'b0;
    end else begin
      mem_rd_reg <= 1'b0;
      mem_wr_reg <= 1'b0;
      rd_dly_reg <= mem_rd_reg;
      if (rd_dly_reg) begin
        busy_reg <= 1'b0;
      end
      // sram fetch; leftovers are never dropped here
      if (fetch_go) begin
        mem_rd_reg   <= 1'b1;
        mem_addr_reg <= {win_base, ptr_reg};
        ptr_reg      <= ptr_reg + 1'b1;
        busy_reg     <= 1'b1;
        ee_pend_reg  <= 1'b0;
      end

      if (start_seen) begin
        state_reg     <= S_ADDR;
        bit_cnt_reg   <= 4'h0;
        sda_oe_reg    <= 1'b0;
        load_pend_reg <= arm_reg;
        arm_reg       <= 1'b0;
        ra_active_reg <= 1'b0;
        ee_pend_reg   <= 1'b0;
        bus_busy_reg  <= 1'b1;
      end else if (stop_seen) begin
        state_reg     <= S_IDLE;
        sda_oe_reg    <= 1'b0;
        arm_reg       <= 1'b1;
        load_pend_reg <= 1'b0;
        ra_active_reg <= 1'b0;
        ee_pend_reg   <= 1'b0;
        bus_busy_reg  <= 1'b0;
      end else begin
        case (state_reg)
          S_ADDR: begin
            if (scl_rise) begin
              shift_reg   <= {shift_reg[6:0], sda_s_reg};
              bit_cnt_reg <= bit_cnt_reg + 1'b1;
            end else if (scl_fall && bit_cnt_reg == `I2CDMA_BITS_BYTE) begin
              if (dma_en && shift_reg[7:1] == slave_addr) begin
                state_reg  <= S_AACK;
                sda_oe_reg <= 1'b1;
                rw_reg     <= shift_reg[0];
                if (shift_reg[0]) begin
                  load_pend_reg <= 1'b0;
                  if (eeprom_mode) begin
                    ee_pend_reg <= 1'b1;
                  end else begin
                    ra_active_reg <= 1'b1;
                  end
                end
              end else begin
                state_reg <= S_IDLE;
              end
            end
          end
          S_AACK, S_MACK: begin
            if (state_reg == S_MACK && scl_rise) begin
              if (sda_s_reg) begin
                state_reg <= S_IDLE;
              end else if (eeprom_mode) begin
                ee_pend_reg <= 1'b1;
              end
            end else if (scl_fall) begin
              bit_cnt_reg <= 4'h0;
              if (rw_reg) begin
                state_reg  <= S_TX;
                shift_reg  <= tx_byte;
                sda_oe_reg <= ~tx_byte[7];
              end else begin
                state_reg  <= S_RX;
                sda_oe_reg <= 1'b0;
              end
            end
          end
          S_RX: begin
            if (scl_rise) begin
              shift_reg   <= {shift_reg[6:0], sda_s_reg};
              bit_cnt_reg <= bit_cnt_reg + 1'b1;
            end else if (scl_fall && bit_cnt_reg == `I2CDMA_BITS_BYTE) begin
              state_reg  <= S_DACK;
              sda_oe_reg <= 1'b1;
              if (load_pend_reg) begin
                ptr_reg       <= shift_reg;
                load_pend_reg <= 1'b0;
              end else begin
                mem_wr_reg    <= 1'b1;
                mem_wdata_reg <= shift_reg;
                mem_addr_reg  <= {win_base, ptr_reg};
                ptr_reg       <= ptr_reg + 1'b1;
              end
            end
          end
          S_DACK: begin
            if (scl_fall) begin
              state_reg   <= S_RX;
              sda_oe_reg  <= 1'b0;
              bit_cnt_reg <= 4'h0;
            end
          end
          S_TX: begin
            if (scl_fall) begin
              if (bit_cnt_reg == `I2CDMA_LAST_TXBIT) begin
                state_reg  <= S_MACK;
                sda_oe_reg <= 1'b0;
              end else begin
                shift_reg   <= {shift_reg[6:0], 1'b1};
                sda_oe_reg  <= ~shift_reg[6];
                bit_cnt_reg <= bit_cnt_reg + 1'b1;
              end
            end
          end
          default: begin
            state_reg <= S_IDLE;
          end
        endcase
      end
    end
  end

  // --------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------
  assign sda_out   = sda_out_reg;
  assign sda_oe    = sda_oe_reg;
  assign mem_addr  = mem_addr_reg;
  assign mem_rd_en = mem_rd_reg;
  assign mem_wr_en = mem_wr_reg;
  assign mem_wdata = mem_wdata_reg;
  assign ptr       = ptr_reg;
  assign bus_busy  = bus_busy_reg;

endmodule // i2cdma_top

// file: verification/i2cdma_props.sv
// Purpose: port checks of the i2c dma engine
// Assumes: widths as in the top module
// Notes:   bound into i2cdma_top
module i2cdma_props (
  // clock and reset
  input wire        clk,
  input wire        rst,
  // watched ports
  input wire        sda_out,
  input wire        sda_oe,
  input wire [2:0]  win_base,
  input wire        fifo_flush,
  input wire [10:0] mem_addr,
  input wire        mem_rd_en,
  input wire        mem_wr_en,
  input wire [7:0]  ptr,
  input wire [2:0]  fifo_level,
  input wire        bus_busy
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [7:0] wa_reg;
  always @(posedge clk) begin
    if (rst) wa_reg <= 8'h00;
    else if (mem_rd_en || mem_wr_en) wa_reg <= mem_addr[7:0];
  end
  sequence s_flush4;
    fifo_flush [*4];
  endsequence
  sequence s_access;
    mem_rd_en || mem_wr_en;
  endsequence
  a_wr_single: assert property (mem_wr_en |=> !mem_wr_en && !mem_rd_en) else $error("write not single");
  a_rd_pulse: assert property (mem_rd_en |=> !mem_rd_en) else $error("read strobe too long");
  a_rd_room: assert property (mem_rd_en |-> fifo_level < 3'h4) else $error("fetch into full fifo");
  a_level_cap: assert property (fifo_level <= 3'h4) else $error("fifo level over depth");
  a_win_base: assert property (s_access |-> mem_addr[10:8] == win_base) else $error("outside window");
  a_ptr_step: assert property (s_access |-> ##[1:2] ptr == wa_reg + 8'h01) else $error("pointer step");
  a_flush_empty: assert property (s_flush4 |=> fifo_level == 3'h0) else $error("flush left data");
  a_flush_block: assert property (fifo_flush |=> !mem_rd_en) else $error("fetch during flush");
  a_fetch_frame: assert property (mem_rd_en |-> bus_busy || $past(bus_busy)) else $error("fetch off bus");
  a_sda_low: assert property (sda_out == 1'b0 && (bus_busy || !sda_oe)) else $error("sda pulled off bus");
endmodule // i2cdma_props

bind i2cdma_top i2cdma_props u_props (.clk(clk), .rst(rst), .sda_out(sda_out), .sda_oe(sda_oe), .win_base(win_base),
  .fifo_flush(fifo_flush), .mem_addr(mem_addr), .mem_rd_en(mem_rd_en), .mem_wr_en(mem_wr_en),
  .ptr(ptr), .fifo_level(fifo_level), .bus_busy(bus_busy));

// file: verification/i2cdma_master.sv
// Purpose: i2c bus master model
// Assumes: sda is the resolved wire with pull-up
// Notes:   scl period 31 clk, scl rests high between frames
module i2cdma_master (
  // clock
  input  wire  clk,
  // bus lines
  input  wire  sda,
  output logic scl,
  output logic sda_m
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask
  // one bit, left with scl high
  task automatic bit_x(input logic b, output logic s);
    scl = 1'b0;
    wt(4);
    sda_m = b;
    wt(12);
    scl = 1'b1;
    wt(7);
    s = sda;
    wt(8);
  endtask
  // start or repeated start
  task automatic start_c();
    logic s;
    bit_x(1'b1, s);
    sda_m = 1'b0;
    wt(8);
  endtask
  task automatic stop_c();
    logic s;
    bit_x(1'b0, s);
    sda_m = 1'b1;
    wt(8);
  endtask
  // eight bits msb first, ninth is ack or nack
  task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q, output logic ninth);
    for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
    bit_x(last, ninth);
  endtask
endmodule // i2cdma_master

// file: verification/testbench.sv
// Purpose: self-checking bench of the i2c dma engine
// Assumes: sram model with one-cycle read latency
// Notes:   sram byte i holds i xor 5A
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; $display("[ERR] %s expected %0h seen %0h", nm, e, g); end end
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk, rst, dma_en, eeprom_mode, fifo_flush, a;
  logic [2:0] win_base;
  logic [6:0] slave_addr;
  logic [7:0] mem_rdata, q;
  logic [7:0] sram [0:2047];
  wire        sda_out, sda_oe, mem_rd_en, mem_wr_en, bus_busy, scl, sda_m, sda;
  wire [10:0] mem_addr;
  wire [7:0]  mem_wdata, ptr;
  wire [2:0]  fifo_level;
  int         errors, n_checks;
  assign sda = (sda_oe ? sda_out : 1'b1) & sda_m;
  i2cdma_master m (.clk(clk), .sda(sda), .scl(scl), .sda_m(sda_m));
  i2cdma_top dut (.clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .dma_en(dma_en), .eeprom_mode(eeprom_mode), .win_base(win_base), .slave_addr(slave_addr),
    .fifo_flush(fifo_flush), .mem_addr(mem_addr), .mem_rd_en(mem_rd_en), .mem_wr_en(mem_wr_en),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .ptr(ptr), .fifo_level(fifo_level), .bus_busy(bus_busy));
  // ------------------------------------------------
  // clock, sram, timeout
  // ------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // unread data lines show the inverse of the last value
  // sram filled with i xor 5A while reset is held
  always @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < 2048; i++) sram[i] <= i[7:0] ^ 8'h5A;
      mem_rdata <= 8'h00;
    end else begin
      if (mem_wr_en) sram[mem_addr] <= mem_wdata;
      mem_rdata <= mem_rd_en ? sram[mem_addr] : ~mem_rdata;
    end
  end
  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ------------------------------------------------
  // bus tasks
  // ------------------------------------------------
  task automatic adr(input logic rw, input logic e);
    m.start_c();
    m.xfer({7'h2A, rw}, 1'b1, q, a);
    `CHK("addr ack", e, a)
  endtask
  task automatic wr(input logic [7:0] d);
    m.xfer(d, 1'b1, q, a);
    `CHK("wr ack", 1'b0, a)
  endtask
  task automatic rd(input logic nack, input logic [7:0] e);
    m.xfer(8'hFF, nack, q, a);
    `CHK("rd byte", e, q)
  endtask
  // ------------------------------------------------
  // tests
  // ------------------------------------------------
  initial begin
    rst = 1'b1;
    dma_en = 1'b1;
    eeprom_mode = 1'b0;
    win_base = 3'h5;
    slave_addr = 7'h2A;
    fifo_flush = 1'b0;
    fork
      begin
        repeat (30000) @(posedge clk);
        errors++;
        report_and_stop();
      end
    join_none
    repeat (10) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    `CHK("ptr rst", 8'h00, ptr)
    `CHK("level rst", 3'h0, fifo_level)
    // pointer load, then writes across the wrap
    adr(1'b0, 1'b0);
    wr(8'hFE);
    wr(8'h11);
    wr(8'h22);
    wr(8'h33);
    m.stop_c();
    `CHK("wr FE", 8'h11, sram[11'h5FE])
    `CHK("wr FF", 8'h22, sram[11'h5FF])
    `CHK("wr 00", 8'h33, sram[11'h500])
    `CHK("ptr wrap", 8'h01, ptr)
    // repeated start does not re-arm loading
    adr(1'b0, 1'b0);
    wr(8'h40);
    wr(8'hA1);
    adr(1'b0, 1'b0);
    wr(8'hB2);
    m.stop_c();
    `CHK("rs data", 8'hB2, sram[11'h541])
    `CHK("rs ptr", 8'h42, ptr)
    // read-ahead fill, refill, leftovers
    adr(1'b0, 1'b0);
    wr(8'h10);
    adr(1'b1, 1'b0);
    `CHK("ra fill", 3'h4, fifo_level)
    `CHK("ra ptr", 8'h14, ptr)
    rd(1'b0, 8'h10 ^ 8'h5A);
    rd(1'b1, 8'h11 ^ 8'h5A);
    `CHK("ra refill", 3'h4, fifo_level)
    `CHK("ra ptr2", 8'h16, ptr)
    m.stop_c();
    `CHK("ra keep", 3'h4, fifo_level)
    adr(1'b1, 1'b0);
    rd(1'b1, 8'h12 ^ 8'h5A);
    m.stop_c();
    fifo_flush = 1'b1;
    repeat (4) @(negedge clk);
    fifo_flush = 1'b0;
    @(negedge clk);
    `CHK("flushed", 3'h0, fifo_level)
    // eeprom single-byte reads
    eeprom_mode = 1'b1;
    adr(1'b0, 1'b0);
    wr(8'h80);
    adr(1'b1, 1'b0);
    `CHK("ee one", 8'h81, ptr)
    rd(1'b0, 8'h80 ^ 8'h5A);
    `CHK("ee ack", 8'h82, ptr)
    rd(1'b1, 8'h81 ^ 8'h5A);
    m.stop_c();
    `CHK("ee nack", 8'h82, ptr)
    // refusals: engine off, foreign address
    dma_en = 1'b0;
    adr(1'b0, 1'b1);
    m.stop_c();
    dma_en = 1'b1;
    slave_addr = 7'h15;
    adr(1'b0, 1'b1);
    m.stop_c();
    // reset in mid-transfer re-arms pointer loading without a stop
    slave_addr = 7'h2A;
    adr(1'b0, 1'b0);
    wr(8'h60);
    `CHK("busy mid", 1'b1, bus_busy)
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    `CHK("busy rst", 1'b0, bus_busy)
    `CHK("ptr rst2", 8'h00, ptr)
    adr(1'b0, 1'b0);
    wr(8'h70);
    wr(8'hC3);
    m.stop_c();
    `CHK("rst load", 8'hC3, sram[11'h570])
    `CHK("rst ptr", 8'h71, ptr)
    report_and_stop();
  end
endmodule // testbench
